// ### core/rco_bcd_cnt.sv
`timescale 1ns/100ps
module rco_bcd_cnt #(
  parameter int DIGITS = 6
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic clr,
  input wire logic inc,
  // Count
  output logic [DIGITS*4-1:0] digits,
  output logic ovf
);
  logic [DIGITS*4-1:0] next_digits;
  logic carry;

  always_comb begin
    carry = inc;
    next_digits = digits;
    for (int i = 0; i < DIGITS; i++) begin
      if (carry) begin
        if (digits[i*4 +: 4] == 4'h9) begin
          next_digits[i*4 +: 4] = 4'h0;
        end else begin
          next_digits[i*4 +: 4] = digits[i*4 +: 4] + 4'h1;
          carry = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      digits <= '0;
      ovf <= 1'b0;
    end else if (clr) begin
      digits <= '0;
      ovf <= 1'b0;
    end else begin
      digits <= next_digits;
      if (carry) begin
        ovf <= 1'b1;
      end
    end
  end

  chk_bcd_digit_range: assert property (@(posedge clk) disable iff (!rst_n)
    digits[DIGITS*4-1 -: 4] <= 4'h9 && digits[3:0] <= 4'h9)
    else $error("bcd digit out of range");
endmodule // rco_bcd_cnt

// ### core/rco_byte_ser.sv
`timescale 1ns/100ps
module rco_byte_ser import rco_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Frame hand-off
  rco_frame_if.ser f
);
  logic [FRAME_W-1:0] sh;
  logic [3:0] left;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh <= '0;
      left <= 4'h0;
    end else if (f.load && left == 4'h0) begin
      sh <= f.frame;
      left <= f.len;
    end else if (f.pop && left != 4'h0) begin
      sh <= {sh[FRAME_W-9:0], 8'h00};
      left <= left - 4'h1;
    end
  end

  assign f.busy = left != 4'h0;
  assign f.valid = left != 4'h0;
  assign f.byte_q = sh[FRAME_W-1 -: 8];
  assign f.last = left == 4'h1;

  chk_eoi_final_byte: assert property (@(posedge clk) disable iff (!rst_n)
    f.pop && f.last |=> !f.valid)
    else $error("frame continued after end flag");
endmodule // rco_byte_ser

// ### core/rco_counter.sv
// Local design decisions: the register addresses and register access over APB.
`timescale 1ns/100ps
module rco_counter import rco_pkg::*; #(
  parameter int CYC_PER_MS = MS_NS / CLK_PERIOD_NS,
  // Identity byte, value is arbitrary
  parameter logic [7:0] ID_CODE = 8'hA5
) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Measurement inputs
  input wire logic chan_a,
  input wire logic chan_b,
  input wire logic chan_c,
  input wire logic [7:0] start_phase,
  input wire logic [7:0] stop_phase,
  // Front panel and health
  input wire logic reset_key,
  input wire logic hw_error,
  input wire logic self_fail
);
  localparam int CW = $clog2(CYC_PER_MS + 1);

  rco_frame_if f();
  rco_meas_t state;
  logic [5:0] sy1, sy2, sy3, rise;
  logic [15:0] ph1, ph2;
  logic a_rise, b_rise, c_rise, rk_rise, hwe_rise, fail_rise;
  logic [4:0] pre_cnt;
  logic c_div, ev_edge, tb_tick, gate, cnt_clr, gate_due;
  logic [CW-1:0] ms_cyc;
  logic [16:0] ms_done, gate_ms;
  logic [7:0] st_q, sp_q, params, trig_a, trig_b, err_code, err_new;
  logic [23:0] ev_dig, tm_dig;
  logic ev_ovf, tm_ovf, data_ready, hs_on, raw_mode, raw_go;
  logic [2:0] func;
  logic [15:0] norm, offset;
  logic err_state, err_flag, fail_flag, local_mode, err_ev;
  logic apb_done, wr_ok, rd_ok, cmd_wr, cmd_ok, cmd_clr, bad_op;
  logic [7:0] op, arg;
  logic [31:0] rd_val;
  logic [1:0] pend;
  logic [11:0] cal_mem [32];
  logic [FRAME_W-1:0] raw_frame, tc_frame;

  function automatic logic [23:0] ovf_pack(input logic [23:0] d,
                                          input logic o);
    return {o ? OVF_NIBBLE : d[23:20], d[19:0]};
  endfunction

  // Input synchronisers, third stage only for edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sy1 <= 6'h00;
      sy2 <= 6'h00;
      sy3 <= 6'h00;
      ph1 <= 16'h0000;
      ph2 <= 16'h0000;
    end else begin
      sy1 <= {chan_a, chan_b, chan_c, reset_key, hw_error, self_fail};
      sy2 <= sy1;
      sy3 <= sy2;
      ph1 <= {start_phase, stop_phase};
      ph2 <= ph1;
    end
  end
  assign rise = sy2 & ~sy3;
  assign {a_rise, b_rise, c_rise, rk_rise, hwe_rise, fail_rise} = rise;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt <= 5'h00;
      c_div <= 1'b0;
    end else begin
      c_div <= 1'b0;
      if (c_rise) begin
        if (pre_cnt == 5'(PRESCALE_C - 1)) begin
          pre_cnt <= 5'h00;
          c_div <= 1'b1;
        end else begin
          pre_cnt <= pre_cnt + 5'h01;
        end
      end
    end
  end

  always_comb begin
    case (func)
      F_RATIO: begin
        ev_edge = b_rise;
        tb_tick = a_rise;
      end
      F_THIRD_CHANNEL_FREQUENCY: begin
        ev_edge = c_div;
        tb_tick = 1'b1;
      end
      default: begin
        ev_edge = a_rise;
        tb_tick = 1'b1;
      end
    endcase
  end

  // Gate time in milliseconds
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ms_cyc <= '0;
      ms_done <= 17'h00000;
    end else if (state != M_GATE) begin
      ms_cyc <= '0;
      ms_done <= 17'h00000;
    end else if (ms_cyc == CW'(CYC_PER_MS - 1)) begin
      ms_cyc <= '0;
      ms_done <= ms_done + 17'h00001;
    end else begin
      ms_cyc <= ms_cyc + CW'(1);
    end
  end
  assign gate_due = ms_done >= gate_ms;

  // gate opens and closes on input edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= M_IDLE;
      gate <= 1'b0;
      cnt_clr <= 1'b0;
      st_q <= 8'h00;
      sp_q <= 8'h00;
    end else begin
      cnt_clr <= 1'b0;
      if (err_state) begin
        state <= M_IDLE;
        gate <= 1'b0;
      end else begin
        case (state)
          M_IDLE: begin
            cnt_clr <= 1'b1;
            state <= M_ARM;
          end
          M_ARM: if (ev_edge) begin
            gate <= 1'b1;
            st_q <= ph2[15:8];
            state <= M_GATE;
          end
          M_GATE: if (gate_due && ev_edge) begin
            gate <= 1'b0;
            sp_q <= ph2[7:0];
            state <= M_DONE;
          end
          M_DONE: if (!raw_mode || raw_go) begin
            state <= M_IDLE;
          end
          default: state <= M_IDLE;
        endcase
      end
    end
  end

  rco_bcd_cnt #(.DIGITS(6)) u_ev (
    .clk(pclk),
    .rst_n(presetn),
    .clr(cnt_clr),
    .inc(gate && ev_edge),
    .digits(ev_dig),
    .ovf(ev_ovf)
  );

  rco_bcd_cnt #(.DIGITS(6)) u_tm (
    .clk(pclk),
    .rst_n(presetn),
    .clr(cnt_clr),
    .inc(gate && tb_tick),
    .digits(tm_dig),
    .ovf(tm_ovf)
  );

  rco_byte_ser u_ser (
    .clk(pclk),
    .rst_n(presetn),
    .f(f)
  );

  // raw output only for capable functions
  assign raw_mode = hs_on && hs_capable(func);

  assign raw_frame = {ovf_pack(ev_dig, ev_ovf), ovf_pack(tm_dig, tm_ovf),
                      func == F_RATIO ? 16'h0000 : {st_q, sp_q}, 32'h0};

  always_comb begin
    tc_frame = '0;
    for (int i = 0; i < 4; i++) begin
      for (int d = 0; d < 3; d++) begin
        tc_frame[FRAME_W-1-(i*3+d)*8 -: 8] = {ASCII_HI,
          cal_mem[{func, 2'(i)}][(2-d)*4 +: 4]};
      end
    end
  end

  // raw counts leave once serializer is free
  assign raw_go = state == M_DONE && raw_mode && !f.busy && !f.load &&
                  pend == 2'h0 && !cmd_ok;

  // Frame loader; pending replies go ahead of raw data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      f.load <= 1'b0;
      f.frame <= '0;
      f.len <= 4'h0;
      pend <= 2'h0;
    end else begin
      f.load <= 1'b0;
      if (cmd_ok && op == OP_TC) begin
        pend <= 2'h1;
      end else if (cmd_ok && op == OP_TE) begin
        pend <= 2'h2;
      end else if (cmd_ok && op == OP_ID) begin
        pend <= 2'h3;
      end else if (!f.busy && !f.load && pend != 2'h0) begin
        f.load <= 1'b1;
        pend <= 2'h0;
        f.len <= pend == 2'h1 ? 4'(CAL_BYTES) : 4'h1;
        case (pend)
          2'h1: f.frame <= tc_frame;
          2'h2: f.frame <= {err_code, 88'h0};
          default: f.frame <= {ID_CODE, 88'h0};
        endcase
      end else if (raw_go) begin
        f.load <= 1'b1;
        f.len <= 4'(RAW_BYTES);
        f.frame <= raw_frame;
      end
    end
  end

  // APB decode and read mux
  assign apb_done = psel && penable && pready;
  assign wr_ok = apb_done && pwrite && rd_ok;
  assign op = pwdata[7:0];
  assign arg = pwdata[15:8];
  assign cmd_wr = wr_ok && paddr == A_CMD;
  assign cmd_ok = cmd_wr && (!err_state || op == OP_INIT || op == OP_TE ||
                  op == OP_ID || op == OP_DCL || op == OP_SDC);
  assign cmd_clr = cmd_ok && (op == OP_INIT || op == OP_DCL ||
                   op == OP_SDC);
  assign bad_op = op == 8'h00 || op > OP_PARAM;
  // Pop only a byte that the read itself reported valid
  assign f.pop = apb_done && !pwrite && paddr == A_OUTDATA && prdata[9];

  always_comb begin
    rd_ok = 1'b1;
    case (paddr)
      A_CMD, A_CAL: rd_val = 32'h0;
      A_STATUS: rd_val = 32'({local_mode, fail_flag, err_flag, 1'h0,
                              data_ready});
      A_OUTDATA: rd_val = {22'h0, f.valid, f.last, f.byte_q};
      A_CONFIG: rd_val = {14'h0, raw_mode, hs_on, params, 5'h0, func};
      A_GATE: rd_val = {15'h0, gate_ms};
      A_ERR: rd_val = {23'h0, err_state, err_code};
      A_EVENT: rd_val = {8'h0, ovf_pack(ev_dig, ev_ovf)};
      A_TIME: rd_val = {8'h0, ovf_pack(tm_dig, tm_ovf)};
      A_TRIG: rd_val = {16'h0, trig_b, trig_a};
      A_MATH: rd_val = {norm, offset};
      default: begin
        rd_val = 32'h0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else if (psel && penable && !pready) begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0 : rd_val;
      pslverr <= !rd_ok;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  always_ff @(posedge pclk) begin
    if (wr_ok && paddr == A_CAL) begin
      cal_mem[pwdata[16:12]] <= pwdata[11:0];
    end
  end

  // Result ready: set wins over read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_ready <= 1'b0;
    end else if (state == M_GATE && gate_due && ev_edge && !err_state) begin
      data_ready <= 1'b1;
    end else if (apb_done && !pwrite && paddr == A_EVENT) begin
      data_ready <= 1'b0;
    end
  end

  // Configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func <= F_FREQ_A;
      params <= RST_PARAMS;
      hs_on <= 1'b0;
      gate_ms <= RST_GATE_MS;
      trig_a <= RST_TRIG;
      trig_b <= RST_TRIG;
      norm <= RST_NORM;
      offset <= RST_OFFSET;
    end else if (cmd_ok) begin
      case (op)
        OP_INIT: begin
          func <= F_FREQ_A;
          params <= RST_PARAMS;
          hs_on <= 1'b0;
          gate_ms <= RST_GATE_MS;
          trig_a <= RST_TRIG;
          trig_b <= RST_TRIG;
          norm <= RST_NORM;
          offset <= RST_OFFSET;
        end
        OP_HS_ON: hs_on <= 1'b1;
        OP_HS_OFF: hs_on <= 1'b0;
        OP_FUNC: begin
          func <= arg[2:0];
          params <= preset(arg[2:0]);
        end
        OP_PARAM: if ((arg & disallowed(func)) == 8'h00) begin
          params <= params | arg;
        end
        default: ;
      endcase
    end else if (wr_ok) begin
      case (paddr)
        A_GATE: gate_ms <= pwdata[16:0];
        A_TRIG: {trig_b, trig_a} <= pwdata[15:0];
        A_MATH: {norm, offset} <= pwdata;
        default: ;
      endcase
    end
  end

  always_comb begin
    err_ev = 1'b1;
    if (hwe_rise) begin
      err_new = ERR_HW;
    end else if (cmd_ok && op == OP_PARAM &&
                 (arg & disallowed(func)) != 8'h00) begin
      err_new = ERR_DISALLOW;
    end else begin
      err_new = ERR_BAD_CMD;
      err_ev = cmd_ok && bad_op;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_state <= 1'b0;
      err_code <= 8'h00;
      err_flag <= 1'b0;
      fail_flag <= 1'b0;
      local_mode <= 1'b1;
    end else if (rk_rise) begin
      err_state <= 1'b0;
      err_code <= 8'h00;
      err_flag <= 1'b0;
      fail_flag <= 1'b0;
      local_mode <= 1'b1;
    end else begin
      if (cmd_wr) begin
        local_mode <= 1'b0;
      end
      if (cmd_ok && op == OP_TE) begin
        err_flag <= 1'b0;
      end
      if (cmd_clr && err_state && err_code < ERR_UPPER && !fail_flag) begin
        err_state <= 1'b0;
        err_flag <= 1'b0;
      end
      if (err_ev && (!local_mode || cmd_wr)) begin
        err_state <= 1'b1;
        err_code <= err_new;
        err_flag <= 1'b1;
      end
      if (fail_rise) begin
        err_state <= 1'b1;
        err_code <= FAIL_NUM;
        fail_flag <= 1'b1;
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_raw_frame_len: assert property (
    raw_go |=> f.load && f.len == 4'h8)
    else $error("raw frame is not eight bytes");
  chk_ovf_top_nibble: assert property (
    raw_go && ev_ovf |=> f.frame[95:92] == 4'hF)
    else $error("event overflow nibble missing");
  chk_raw_func_only: assert property (
    f.load && f.len == 4'h8 |-> hs_capable(func))
    else $error("raw output in wrong function");
  chk_ratio_no_interp: assert property (
    raw_go && func == F_RATIO |=> f.frame[47:32] == 16'h0000)
    else $error("ratio frame carries interpolator data");
  chk_cmd_filter_err: assert property (
    err_state && cmd_wr && op == OP_HS_ON |=> hs_on == $past(hs_on))
    else $error("command obeyed in error state");
  chk_upper_err_held: assert property (
    err_state && err_code >= ERR_UPPER && !rk_rise |=> err_state)
    else $error("upper error cleared without key");
  chk_query_flag_clear: assert property (
    err_state && cmd_ok && op == OP_TE && !err_ev && !fail_rise && !rk_rise
      |=> !err_flag && err_state)
    else $error("error query flag handling wrong");
  chk_fail_flag_held: assert property (
    fail_flag && !rk_rise |=> fail_flag)
    else $error("failure flag cleared without key");
  chk_gate_suspend: assert property (
    err_state |=> !gate ##1 !gate)
    else $error("gate open during error state");
endmodule // rco_counter

// ### core/rco_frame_if.sv
`timescale 1ns/100ps
interface rco_frame_if import rco_pkg::*; ();
  logic load;
  logic [FRAME_W-1:0] frame;
  logic [3:0] len;
  logic pop;
  logic busy;
  logic valid;
  logic last;
  logic [7:0] byte_q;
  modport src(output load, frame, len, pop, input busy, valid, last, byte_q);
  modport ser(input load, frame, len, pop, output busy, valid, last, byte_q);
endinterface

// ### core/rco_pkg.sv
package rco_pkg;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int PRESCALE_C = 20;
  localparam int RAW_BYTES = 8;
  localparam int CAL_BYTES = 12;
  localparam int FRAME_W = CAL_BYTES * 8;
  // 256 phase steps span one 100 ns period; 128 is 50 ns
  localparam int INTERP_STEPS = 256;
  // Register byte addresses
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_OUTDATA = 8'h08;
  localparam logic [7:0] A_CONFIG = 8'h0C;
  localparam logic [7:0] A_GATE = 8'h10;
  localparam logic [7:0] A_ERR = 8'h14;
  localparam logic [7:0] A_CAL = 8'h18;
  localparam logic [7:0] A_EVENT = 8'h1C;
  localparam logic [7:0] A_TIME = 8'h20;
  localparam logic [7:0] A_TRIG = 8'h24;
  localparam logic [7:0] A_MATH = 8'h28;
  // Command opcodes
  localparam logic [7:0] OP_INIT = 8'h01;
  localparam logic [7:0] OP_HS_OFF = 8'h02;
  localparam logic [7:0] OP_HS_ON = 8'h03;
  localparam logic [7:0] OP_TC = 8'h04;
  localparam logic [7:0] OP_TE = 8'h05;
  localparam logic [7:0] OP_ID = 8'h06;
  localparam logic [7:0] OP_DCL = 8'h07;
  localparam logic [7:0] OP_SDC = 8'h08;
  localparam logic [7:0] OP_FUNC = 8'h09;
  localparam logic [7:0] OP_PARAM = 8'h0A;
  // Functions
  localparam logic [2:0] F_FREQ_A = 3'h0;
  localparam logic [2:0] F_PERIOD = 3'h1;
  localparam logic [2:0] F_TINT = 3'h2;
  localparam logic [2:0] F_RATIO = 3'h3;
  localparam logic [2:0] F_THIRD_CHANNEL_FREQUENCY = 3'h4;
  localparam logic [2:0] F_TOTAL = 3'h5;
  localparam logic [2:0] F_DVM = 3'h6;
  // Parameter enables
  localparam logic [7:0] P_AUTO_TRIG = 8'h01;
  localparam logic [7:0] P_AUTO_ATT = 8'h02;
  localparam logic [7:0] P_AVG = 8'h04;
  localparam logic [7:0] P_MATH = 8'h08;
  localparam logic [7:0] P_ARM = 8'h10;
  localparam logic [7:0] RST_PARAMS = P_AUTO_TRIG | P_AUTO_ATT;
  localparam logic [16:0] RST_GATE_MS = 17'h0012C;
  localparam logic [15:0] RST_NORM = 16'h0001;
  localparam logic [15:0] RST_OFFSET = 16'h0000;
  localparam logic [7:0] RST_TRIG = 8'h00;
  // Error numbers, major digit high nibble
  localparam logic [7:0] ERR_BAD_CMD = 8'h10;
  localparam logic [7:0] ERR_DISALLOW = 8'h20;
  localparam logic [7:0] ERR_HW = 8'h50;
  localparam logic [7:0] ERR_UPPER = 8'h50;
  localparam logic [7:0] FAIL_NUM = 8'h01;
  localparam logic [3:0] ASCII_HI = 4'h3;
  localparam logic [3:0] OVF_NIBBLE = 4'hF;
  localparam int ST_READY = 0;
  localparam int ST_ERR = 2;
  localparam int ST_FAIL = 3;
  localparam int ST_LOCAL = 4;

  typedef enum logic [3:0] {
    M_IDLE = 4'b0001, M_ARM = 4'b0010, M_GATE = 4'b0100, M_DONE = 4'b1000
  } rco_meas_t;

  function automatic logic hs_capable(input logic [2:0] f);
    return f <= F_THIRD_CHANNEL_FREQUENCY;
  endfunction

  function automatic logic [7:0] disallowed(input logic [2:0] f);
    case (f)
      F_RATIO: return P_AVG | P_MATH;
      F_THIRD_CHANNEL_FREQUENCY: return P_ARM;
      F_DVM: return P_AVG | P_ARM;
      default: return 8'h00;
    endcase
  endfunction

  function automatic logic [7:0] preset(input logic [2:0] f);
    case (f)
      F_RATIO: return P_AUTO_TRIG;
      F_DVM: return 8'h00;
      default: return RST_PARAMS;
    endcase
  endfunction
endpackage

// ### testbench/raw_count_output_error_state_tb.sv
`timescale 1ns/100ps
module raw_count_output_error_state_tb import rco_pkg::*;;
  // Identity value is arbitrary
  localparam logic [7:0] IDC = 8'h5A;
  logic pclk, presetn, chan_a, chan_b, chan_c, reset_key, hw_error;
  logic self_fail, psel, penable, pwrite, pready, pslverr;
  logic [2:0] kick;
  logic [7:0] paddr, start_phase, stop_phase;
  logic [31:0] pwdata, prdata, rv;
  logic [3:0] cal [12];
  logic [7:0] clr_ops [3] = '{OP_DCL, OP_SDC, OP_INIT};
  logic [2:0] fns [5] = '{F_FREQ_A, F_PERIOD, F_TINT, F_THIRD_CHANNEL_FREQUENCY, F_RATIO};
  int errors, total_checks, seed, cyc;

  assign {reset_key, hw_error, self_fail} = kick;

  rco_counter #(.CYC_PER_MS(10), .ID_CODE(IDC)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_a(chan_a),
    .chan_b(chan_b), .chan_c(chan_c), .start_phase(start_phase),
    .stop_phase(stop_phase), .reset_key(reset_key),
    .hw_error(hw_error), .self_fail(self_fail));

  rco_host host (
    .pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask

  task automatic rd(logic [7:0] a);
    host.xfer(1'b0, a, 32'h0);
    rv = host.rdata;
  endtask

  task automatic cmd(logic [7:0] op, logic [7:0] arg);
    wr(A_CMD, {16'h0000, arg, op});
  endtask

  // Poll the output port until a byte is waiting, then take it
  task automatic popb();
    int n;
    n = 0;
    rd(A_OUTDATA);
    while (rv[9] !== 1'b1 && n < 300) begin
      n++;
      rd(A_OUTDATA);
    end
    chk("valid", 32'h1, {31'h0, rv[9]});
  endtask

  task automatic pulse(logic [2:0] v);
    kick <= v;
    repeat (4) @(posedge pclk);
    kick <= 3'b000;
    repeat (6) @(posedge pclk);
  endtask

  function automatic logic isbcd(logic [7:0] b);
    return b[7:4] <= 4'h9 && b[3:0] <= 4'h9;
  endfunction

  function automatic int bcdv(logic [7:0] b);
    return b[7:4] * 10 + b[3:0];
  endfunction

  function automatic int numfix(int n);
    return (n <= -5 && n >= -256) ? n + 256 : n;
  endfunction

  task automatic chk_init();
    rd(A_GATE);
    chk("gate", {15'h0, RST_GATE_MS}, rv);
    rd(A_CONFIG);
    chk("config", {16'h0, RST_PARAMS, 5'h00, F_FREQ_A},
        rv & 32'hFFFF);
    rd(A_MATH);
    chk("math", {RST_NORM, RST_OFFSET}, rv);
    rd(A_TRIG);
    chk("trig", {16'h0, RST_TRIG, RST_TRIG}, rv);
  endtask

  task automatic frame(logic [2:0] f, logic keep);
    logic [7:0] b [8];
    for (int k = 0; k < 8; k++) begin
      popb();
      b[k] = rv[7:0];
      chk("eoi", {31'h0, k == 7}, {31'h0, rv[8]});
    end
    if (keep) begin
      chk("st", {24'h0, f == F_RATIO ? 8'h00 : start_phase},
          {24'h0, b[6]});
      chk("sp", {24'h0, f == F_RATIO ? 8'h00 : stop_phase},
          {24'h0, b[7]});
      // Prescaled gates close late, so time may pass 99 counts
      chk("top", 32'h0,
          {b[0], b[1], b[3], f == F_THIRD_CHANNEL_FREQUENCY ? 8'h00 : b[4]});
      chk("bcd", 32'h1, {31'h0, isbcd(b[2]) & isbcd(b[5])});
      if (f == F_FREQ_A) begin
        chk("time", 32'h1, {31'h0, b[5] >= 8'h10 && b[2] <= b[5]});
      end
      if (f == F_THIRD_CHANNEL_FREQUENCY) begin
        // Prescaled edges are at least forty cycles apart
        chk("prescale", 32'h1, {31'h0, bcdv(b[2]) >= 1 &&
            bcdv(b[2]) * PRESCALE_C <= bcdv(b[4]) * 100 + bcdv(b[5])});
      end
    end
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    {chan_a, chan_b, chan_c} <= 3'($random(seed));
    cyc++;
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    seed = 25;
    presetn = 1'b0;
    kick = 3'b000;
    {chan_a, chan_b, chan_c} = 3'b000;
    start_phase = 8'h80;
    stop_phase = 8'h00;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_init();
    rd(A_STATUS);
    chk("status", 32'h10, rv & 32'h1C);
    rd(8'h40);
    chk("unmapped", 32'h1, {31'h0, host.rerr});
    foreach (clr_ops[i]) begin
      if (clr_ops[i] == OP_INIT) begin
        wr(A_GATE, 32'h5);
        wr(A_TRIG, 32'($random(seed)) & 32'hFFFF);
        wr(A_MATH, 32'($random(seed)));
      end
      cmd(OP_FUNC, {5'h00, F_RATIO});
      rd(A_CONFIG);
      chk("preset", {24'h0, P_AUTO_TRIG}, {24'h0, rv[15:8]});
      cmd(OP_PARAM, P_AVG);
      rd(A_ERR);
      chk("err", {23'h0, 1'b1, ERR_DISALLOW}, {23'h0, rv[8:0]});
      if (i == 0) begin
        rd(A_STATUS);
        chk("flag", 32'h4, rv & 32'hC);
        cmd(OP_FUNC, {5'h00, F_FREQ_A});
        rd(A_CONFIG);
        chk("filter", {29'h0, F_RATIO}, {29'h0, rv[2:0]});
        cmd(OP_TE, 8'h00);
        popb();
        chk("te", {22'h0, 2'b11, ERR_DISALLOW}, {22'h0, rv[9:0]});
        rd(A_STATUS);
        chk("te flag", 32'h0, rv & 32'hC);
        rd(A_ERR);
        chk("te state", 32'h100, rv & 32'h100);
      end
      cmd(clr_ops[i], 8'h00);
      rd(A_ERR);
      chk("cleared", 32'h0, rv & 32'h100);
    end
    chk_init();
    pulse(3'b010);
    foreach (clr_ops[i]) cmd(clr_ops[i], 8'h00);
    rd(A_ERR);
    chk("upper", {23'h0, 1'b1, ERR_HW}, {23'h0, rv[8:0]});
    cmd(OP_ID, 8'h00);
    popb();
    chk("id", {22'h0, 2'b11, IDC}, {22'h0, rv[9:0]});
    pulse(3'b001);
    cmd(OP_TE, 8'h00);
    popb();
    chk("te fail", {22'h0, 2'b11, FAIL_NUM}, {22'h0, rv[9:0]});
    rd(A_STATUS);
    chk("fail", 32'h8, rv & 32'h8);
    pulse(3'b100);
    rd(A_STATUS);
    chk("key", 32'h10, rv & 32'h1C);
    // Host fetches calibration before raw data
    cmd(OP_FUNC, {5'h00, F_FREQ_A});
    for (int k = 0; k < 12; k++) cal[k] = 4'($unsigned($random(seed)) % 10);
    for (int k = 0; k < 4; k++) begin
      wr(A_CAL, {15'h0, 5'(k), cal[3*k], cal[3*k+1], cal[3*k+2]});
    end
    cmd(OP_TC, 8'h00);
    for (int k = 0; k < 12; k++) begin
      popb();
      chk("cal", {22'h0, 1'b1, k == 11, ASCII_HI, cal[k]}, {22'h0, rv[9:0]});
    end
    chk("fold", 32'h000000FB, 32'(numfix(-5)));
    stop_phase <= 8'($random(seed));
    cmd(OP_HS_ON, 8'h00);
    wr(A_GATE, 32'h1);
    foreach (fns[i]) begin
      cmd(OP_FUNC, {5'h00, fns[i]});
      // Two frames may straddle the function change
      frame(fns[i], 1'b0);
      frame(fns[i], 1'b0);
      frame(fns[i], 1'b1);
    end
    cmd(OP_FUNC, {5'h00, F_TOTAL});
    rd(A_CONFIG);
    chk("raw only", 32'h10000, rv & 32'h30000);
    cmd(OP_HS_OFF, 8'h00);
    rd(A_CONFIG);
    chk("raw off", 32'h0, rv & 32'h10000);
    close_out();
  end
endmodule // raw_count_output_error_state_tb

// ### testbench/rco_host.sv
`timescale 1ns/100ps
module rco_host (
  // Clock
  input wire logic pclk,
  // Request
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // Answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  logic [31:0] rdata;
  logic rerr;

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Called just after a rising edge; returns just after one too
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask
endmodule // rco_host
